// ===== bench/i2c_far_master.sv
// far-side bus master model, open drain with pull-ups
`timescale 1ns/1ps
module i2c_far_master (
   // clock
   input wire logic clk_i,
   // wire levels
   input wire logic scl_i,
   input wire logic sda_i,
   // drive, low pulls the wire
   output logic scl_rel_o = 1'b1,
   output logic sda_rel_o = 1'b1
);
   localparam int HB = 10;
   task automatic wt();
      repeat (HB) @(posedge clk_i);
   endtask : wt
   // sda falls while scl high; also a repeated start
   task automatic start();
      sda_rel_o <= 1'b1;
      wt();
      scl_rel_o <= 1'b1;
      wt();
      sda_rel_o <= 1'b0;
      wt();
      scl_rel_o <= 1'b0;
      wt();
   endtask : start
   task automatic stop();
      sda_rel_o <= 1'b0;
      wt();
      scl_rel_o <= 1'b1;
      wt();
      sda_rel_o <= 1'b1;
      wt();
   endtask : stop
   // msb first, ninth bit released for the acknowledge
   task automatic xfer(input logic [7:0] d, output logic ack);
      logic [8:0] s;
      s = {d, 1'b1};
      for (int i = 8; i >= 0; i--)
      begin
         sda_rel_o <= s[i];
         wt();
         scl_rel_o <= 1'b1;
         // a stretching slave holds the wire; the bench timeout ends a hang
         while (scl_i !== 1'b1)
            @(posedge clk_i);
         wt();
         ack = sda_i;
         scl_rel_o <= 1'b0;
         wt();
      end
   endtask : xfer
endmodule : i2c_far_master

// ===== bench/i2c_port_asserts.sv
// concurrent checks on the serial port top-level ports
`timescale 1ns/1ps
module i2c_port_asserts
   import i2c_port_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // apb
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // pins and status
   input wire logic scl_oe_n_o,
   input wire logic sda_oe_n_o,
   input wire logic scl_dir_in_i,
   input wire logic sda_dir_in_i,
   input wire logic pins_to_port_o,
   input wire logic port_interrupt_flag_o
);
   default clocking dc @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic acc;
   logic want_pins;
   assign acc = psel_i && penable_i && pready_o;
   assign want_pins = pwdata_i[C1_EN] &&
      (pwdata_i[3:0] inside {MODE_SLV10_SP, MODE_SLV7_SP, MODE_FW_MST, MODE_MST, MODE_SLV10, MODE_SLV7});
   AST_WAIT_STATE: assert property (psel_i && !penable_i ##1 psel_i && penable_i |-> !pready_o ##1 pready_o)
      else $error("pready not on second access cycle");
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   AST_ERR_READ: assert property (pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0)
      else $error("error response without ready or zero data");
   AST_FLAG_STICKY: assert property (
      port_interrupt_flag_o && !(acc && pwrite_i && paddr_i == OFS_FLAG && pwdata_i[0]) |=> port_interrupt_flag_o)
      else $error("interrupt flag dropped without a clear");
   AST_PINS_FOLLOW: assert property (
      acc && pwrite_i && paddr_i == OFS_CTRL1 |-> ##2 pins_to_port_o == $past(want_pins, 2))
      else $error("pin ownership does not follow enable and mode");
   AST_IDLE_RELEASE: assert property (!pins_to_port_o [*2] |-> scl_oe_n_o && sda_oe_n_o)
      else $error("pins pulled while port disabled");
   AST_DIR_SDA: assert property (!sda_dir_in_i |=> sda_oe_n_o)
      else $error("data pin pulled while set as output");
   AST_DIR_SCL: assert property (!scl_dir_in_i |=> scl_oe_n_o)
      else $error("clock pin pulled while set as output");
   AST_RESET_QUIET: assert property (@(posedge core_clk_i) disable iff (1'b0)
      !nrst_i |=> scl_oe_n_o && sda_oe_n_o && !pready_o && !port_interrupt_flag_o && !pins_to_port_o)
      else $error("outputs active during reset");
   cover property (acc && pslverr_o);
   cover property ($rose(port_interrupt_flag_o));
   cover property (!sda_oe_n_o && pins_to_port_o);
endmodule : i2c_port_asserts

bind i2c_port i2c_port_asserts i_chk (.*);

// ===== bench/i2c_port_control_and_slave_addressing_tb_top.sv
// self-checking bench for the two-wire serial port
`timescale 1ns/1ps
module i2c_port_control_and_slave_addressing_tb_top;
   import i2c_port_pkg::*;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic dir_in = 1'b1;
   logic [31:0] prdata;
   logic pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, pins, irq;
   logic m_scl, m_sda, scl, sda, er, ack;
   logic [31:0] rd;
   logic [6:0] adr;
   logic [7:0] dat;
   logic [7:0] q [$];
   logic [3:0] modes [7] = '{MODE_SLV10_SP, MODE_SLV7_SP, MODE_FW_MST, MODE_MST, MODE_SLV10, MODE_SLV7, 4'h3};
   int req [4] = '{C2_RXGO, C2_ACKGO, C2_RSTART, C2_STOP};
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int t;
   assign scl = m_scl & (scl_oe_n | scl_o);
   assign sda = m_sda & (sda_oe_n | sda_o);
   initial forever #12.5 core_clk_i = ~core_clk_i;
   i2c_port i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .scl_i(scl), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .scl_dir_in_i(dir_in), .sda_dir_in_i(dir_in), .pins_to_port_o(pins), .port_interrupt_flag_o(irq));
   i2c_far_master i_far (.clk_i(core_clk_i), .scl_i(scl), .sda_i(sda), .scl_rel_o(m_scl), .sda_rel_o(m_sda));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      do
         @(posedge core_clk_i);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_i);
   endtask : apb
   task automatic poll(input logic [7:0] a, input int b);
      for (int n = 0; n < 200; n++)
      begin
         apb(1'b0, a, 32'h0);
         if (rd[b] === 1'b0)
            break;
      end
      chk("poll", rd[b], 1'b0);
   endtask : poll
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         conclude();
      end
   end
   initial
   begin
      void'($urandom(32'hED08AC74));
      repeat (20) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      @(posedge core_clk_i);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset", rd, 32'h0);
      end
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
      foreach (modes[i])
      begin
         apb(1'b1, OFS_CTRL1, {26'h0, 2'h3, modes[i]});
         apb(1'b0, OFS_CTRL1, 32'h0);
         chk("ctrl1", rd, {26'h0, 2'h3, modes[i]});
         chk("pins", pins, i < 6);
      end
      adr = 7'($urandom_range(127, 1));
      dat = 8'($urandom);
      apb(1'b1, OFS_ADDR, {24'h0, adr, 1'b0});
      apb(1'b1, OFS_CTRL1, 32'h36);
      i_far.start();
      i_far.xfer({adr ^ 7'h01, 1'b0}, ack);
      chk("other", {ack, irq}, 2'h2);
      i_far.start();
      i_far.xfer({adr, 1'b0}, ack);
      chk("match", {ack, irq}, 2'h1);
      q.push_back({adr, 1'b0});
      i_far.xfer(dat, ack);
      chk("full", ack, 1'b1);
      apb(1'b0, OFS_CTRL1, 32'h0);
      chk("ovf", rd[C1_OVF], 1'b1);
      apb(1'b0, OFS_DATA, 32'h0);
      chk("buf", rd, q.pop_front());
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("empty", rd[ST_FULL], 1'b0);
      i_far.xfer(dat, ack);
      chk("ovf_nack", ack, 1'b1);
      apb(1'b1, OFS_CTRL1, 32'h36);
      apb(1'b1, OFS_FLAG, 32'h1);
      chk("irq_clr", irq, 1'b0);
      i_far.start();
      i_far.xfer({adr, 1'b0}, ack);
      apb(1'b0, OFS_DATA, 32'h0);
      i_far.xfer(dat, ack);
      q.push_back(dat);
      apb(1'b0, OFS_DATA, 32'h0);
      chk("data", {ack, irq, rd[7:0]}, {2'h1, q.pop_front()});
      for (int g = 0; g < 2; g++)
      begin
         apb(1'b1, OFS_CTRL2, 32'(g) << 7);
         apb(1'b1, OFS_FLAG, 32'h1);
         apb(1'b0, OFS_DATA, 32'h0);
         i_far.start();
         i_far.xfer(BCAST_ADDR, ack);
         chk("bcast", {ack, irq}, {g == 0, g == 1});
      end
      dir_in <= 1'b0;
      apb(1'b0, OFS_DATA, 32'h0);
      i_far.start();
      i_far.xfer({adr, 1'b0}, ack);
      chk("dir", ack, 1'b1);
      dir_in <= 1'b1;
      dat = {TEN_PREFIX, 2'($urandom), 1'b0};
      apb(1'b1, OFS_ADDR, {24'h0, dat});
      apb(1'b1, OFS_CTRL1, 32'h37);
      apb(1'b0, OFS_DATA, 32'h0);
      i_far.start();
      i_far.xfer(dat, ack);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("ten", {ack, rd[ST_UPD], scl_o, sda_o}, 4'h4);
      i_far.stop();
      apb(1'b1, OFS_CTRL1, 32'h28);
      apb(1'b1, OFS_ADDR, 32'h83);
      apb(1'b1, OFS_CTRL2, 32'h1);
      poll(OFS_CTRL2, C2_START);
      apb(1'b1, OFS_DATA, {24'h0, dat});
      apb(1'b1, OFS_DATA, 32'h0);
      apb(1'b1, OFS_CTRL2, 32'h4);
      apb(1'b0, OFS_CTRL1, 32'h0);
      chk("coll", rd[C1_COLL], 1'b1);
      @(negedge scl_oe_n);
      t = cyc;
      @(negedge scl_oe_n);
      chk("period", cyc - t, 32'd16);
      poll(OFS_STATUS, ST_MBUSY);
      apb(1'b0, OFS_CTRL2, 32'h0);
      chk("ctrl2", rd, 32'h40);
      foreach (req[i])
      begin
         apb(1'b1, OFS_CTRL2, 32'h1 << req[i]);
         poll(OFS_CTRL2, req[i]);
      end
      apb(1'b0, OFS_DATA, 32'h0);
      chk("rx", rd, 32'hFF);
      conclude();
   end
endmodule : i2c_port_control_and_slave_addressing_tb_top

// ===== design/i2c_port.sv
// two-wire serial port: apb registers, master sequencer, slave datapath
`timescale 1ns/1ps
module i2c_port (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // apb slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // bus pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // pin direction bits, high means input
   input wire logic scl_dir_in_i,
   input wire logic sda_dir_in_i,
   // status
   output logic pins_to_port_o,
   output logic port_interrupt_flag_o
);
   import i2c_port_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] addr_reload;
      logic [7:0] data_buf;
      logic [7:0] shift;
      logic buf_full;
      logic addr_upd;
      logic rw;
      logic seen_s;
      logic seen_p;
      logic is_data;
      logic pif;
      mstate_t ms;
      logic [1:0] q;
      logic [3:0] mcnt;
      logic m_scl_low;
      logic m_sda_low;
      logic sact;
      logic [3:0] scnt;
      logic [1:0] ten;
      logic hit;
      logic load;
      logic ack;
      logic txbit;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic scl_oe_n;
      logic sda_oe_n;
      logic port_on;
      logic drv_lvl;
   } state_t;
   state_t r, n;

   logic [3:0] mode;
   logic [7:0] wdat;
   logic [7:0] stat;
   logic en, is_master, is_slave, ten_mode, sp_irq, i2c_sel, m_busy;
   logic acc, wr, rd, reg_hit, tick, step, samp, mid;
   logic scl_low, sda_low, tx_shifting;

   line_sense_if ls ();

   line_sense u_sense (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ls(ls)
   );

   rate_gen u_rate (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .reload_i(r.addr_reload[6:0]),
      .run_i(is_master && r.ms != M_IDLE),
      .tick_o(tick)
   );

   assign en = r.ctrl1[C1_EN];
   assign mode = r.ctrl1[C1_MODE_HI:0];
   assign wdat = pwdata_i[7:0];
   assign is_master = en && mode == MODE_MST;
   assign ten_mode = mode == MODE_SLV10_SP || mode == MODE_SLV10;
   assign sp_irq = mode == MODE_SLV10_SP || mode == MODE_SLV7_SP;
   assign is_slave = en && (ten_mode || sp_irq || mode == MODE_SLV7);
   assign i2c_sel = is_master || is_slave || (en && mode == MODE_FW_MST);
   assign m_busy = is_master && (r.ms != M_IDLE || r.ctrl2[C2_ACKGO:C2_START] != 5'h00);
   assign tx_shifting = r.sact && r.rw && r.is_data && r.scnt != 4'h0 && r.scnt <= BYTE_LAST;
   assign acc = psel_i && penable_i && r.ready;
   assign wr = acc && pwrite_i;
   assign rd = acc && !pwrite_i;
   assign reg_hit = paddr_i == OFS_CTRL1 || paddr_i == OFS_CTRL2 || paddr_i == OFS_STATUS
                    || paddr_i == OFS_DATA || paddr_i == OFS_ADDR || paddr_i == OFS_FLAG;
   assign step = tick && r.q == Q_LAST;
   assign samp = tick && r.q == Q_SAMPLE;
   // scl is low in the first and last quarter of a data bit
   assign mid = r.q == 2'h0 || r.q == Q_LAST;

   assign stat[ST_FULL] = r.buf_full;
   assign stat[ST_UPD] = r.addr_upd;
   assign stat[ST_RW] = r.rw;
   assign stat[ST_SEEN_S] = r.seen_s;
   assign stat[ST_SEEN_P] = r.seen_p;
   assign stat[ST_DATA] = r.is_data;
   assign stat[ST_MBUSY] = m_busy;
   assign stat[ST_RSVD] = 1'b0;

   // stretch while release is clear, or while a ten-bit address update is owed
   assign scl_low = is_master ? r.m_scl_low
                    : is_slave && ((r.sact && !r.ctrl1[C1_REL]) || (ten_mode && r.addr_upd));
   assign sda_low = is_master ? r.m_sda_low
                    : is_slave && (r.ack || (r.sact && r.rw && r.is_data && r.scnt < BYTE_LAST && !r.txbit));

   always_comb
   begin
      logic hit;
      logic ok;
      hit = 1'b0;
      ok = 1'b0;
      n = r;
      n.ready = 1'b0;
      n.err = 1'b0;
      // one wait state so read data comes from a flop
      if (psel_i && penable_i && !r.ready)
      begin
         n.ready = 1'b1;
         n.err = !reg_hit;
         n.rdata = 32'h0000_0000;
         if (paddr_i == OFS_CTRL1)
            n.rdata[7:0] = r.ctrl1;
         else if (paddr_i == OFS_CTRL2)
            n.rdata[7:0] = r.ctrl2;
         else if (paddr_i == OFS_STATUS)
            n.rdata[7:0] = stat;
         else if (paddr_i == OFS_DATA)
            n.rdata[7:0] = r.data_buf;
         else if (paddr_i == OFS_ADDR)
            n.rdata[7:0] = r.addr_reload;
         else if (paddr_i == OFS_FLAG)
            n.rdata[0] = r.pif;
      end
      if (rd && paddr_i == OFS_DATA)
         n.buf_full = 1'b0;
      // software writes first; hardware sets below win in the same cycle
      if (wr)
      begin
         if (paddr_i == OFS_CTRL1)
            n.ctrl1 = wdat;
         else if (paddr_i == OFS_CTRL2)
         begin
            n.ctrl2[C2_BCAST] = wdat[C2_BCAST];
            n.ctrl2[C2_ACKVAL] = wdat[C2_ACKVAL];
            if (!m_busy)
               n.ctrl2[C2_ACKGO:C2_START] = wdat[C2_ACKGO:C2_START];
         end
         else if (paddr_i == OFS_DATA)
         begin
            if (m_busy || (is_slave && tx_shifting))
               n.ctrl1[C1_COLL] = 1'b1;
            else
            begin
               n.data_buf = wdat;
               n.shift = wdat;
               if (is_master)
               begin
                  n.ms = M_TX;
                  n.buf_full = 1'b1;
               end
               else if (r.rw)
                  n.buf_full = 1'b1;
            end
         end
         else if (paddr_i == OFS_ADDR)
         begin
            n.addr_reload = wdat;
            n.addr_upd = 1'b0;
         end
         else if (paddr_i == OFS_FLAG && wdat[0])
            n.pif = 1'b0;
      end

      // master sequencer, four quarters per step
      if (!is_master)
      begin
         n.ms = M_IDLE;
         n.q = 2'h0;
         n.m_scl_low = 1'b0;
         n.m_sda_low = 1'b0;
      end
      else
      begin
         if (tick)
            n.q = r.q + 2'h1;
         case (r.ms)
            M_IDLE:
            begin
               n.q = 2'h0;
               n.mcnt = 4'h0;
               if (r.ctrl2[C2_START])
                  n.ms = M_START;
               else if (r.ctrl2[C2_RSTART])
                  n.ms = M_RSTART;
               else if (r.ctrl2[C2_STOP])
                  n.ms = M_STOP;
               else if (r.ctrl2[C2_RXGO])
                  n.ms = M_RX;
               else if (r.ctrl2[C2_ACKGO])
                  n.ms = M_ACK;
            end
            M_START:
            begin
               n.m_sda_low = r.q != 2'h0;
               n.m_scl_low = r.q == Q_LAST;
               if (step)
               begin
                  n.ctrl2[C2_START] = 1'b0;
                  n.ms = M_IDLE;
               end
            end
            M_RSTART:
            begin
               n.m_sda_low = r.q[1];
               n.m_scl_low = mid;
               if (step)
               begin
                  n.ctrl2[C2_RSTART] = 1'b0;
                  n.ms = M_IDLE;
               end
            end
            M_STOP:
            begin
               n.m_sda_low = !r.q[1];
               n.m_scl_low = r.q == 2'h0;
               if (step)
               begin
                  n.ctrl2[C2_STOP] = 1'b0;
                  n.ms = M_IDLE;
               end
            end
            M_TX:
            begin
               n.m_sda_low = r.mcnt < BYTE_LAST && !r.shift[~r.mcnt[2:0]];
               n.m_scl_low = mid;
               if (samp && r.mcnt == BYTE_LAST)
                  n.ctrl2[C2_ACKST] = ls.sda;
               if (step)
               begin
                  n.mcnt = r.mcnt + 4'h1;
                  if (r.mcnt == BYTE_LAST)
                  begin
                     n.ms = M_IDLE;
                     n.pif = 1'b1;
                     n.buf_full = 1'b0;
                  end
               end
            end
            M_RX:
            begin
               n.m_sda_low = 1'b0;
               n.m_scl_low = mid;
               if (samp)
                  n.shift = {r.shift[6:0], ls.sda};
               if (step)
               begin
                  n.mcnt = r.mcnt + 4'h1;
                  if (r.mcnt == MST_RX_LAST)
                  begin
                     n.ms = M_IDLE;
                     n.ctrl2[C2_RXGO] = 1'b0;
                     n.pif = 1'b1;
                     if (r.buf_full)
                        n.ctrl1[C1_OVF] = 1'b1;
                     else
                     begin
                        n.data_buf = r.shift;
                        n.buf_full = 1'b1;
                     end
                  end
               end
            end
            M_ACK:
            begin
               n.m_sda_low = !r.ctrl2[C2_ACKVAL];
               n.m_scl_low = mid;
               if (step)
               begin
                  n.ctrl2[C2_ACKGO] = 1'b0;
                  n.ms = M_IDLE;
               end
            end
            default:
               n.ms = M_IDLE;
         endcase
      end

      // slave datapath, paced by the edges the far master makes
      if (!is_slave)
      begin
         n.sact = 1'b0;
         n.ack = 1'b0;
         n.scnt = 4'h0;
         n.ten = TEN_HI;
      end
      else
      begin
         // next outgoing bit only changes while scl is low
         if (!ls.scl)
            n.txbit = r.shift[7];
         if (ls.start)
         begin
            n.sact = 1'b1;
            n.scnt = 4'h0;
            n.is_data = 1'b0;
            n.ack = 1'b0;
            n.seen_s = 1'b1;
            n.seen_p = 1'b0;
            if (sp_irq)
               n.pif = 1'b1;
         end
         else if (ls.stop)
         begin
            n.sact = 1'b0;
            n.ack = 1'b0;
            n.ten = TEN_HI;
            n.seen_p = 1'b1;
            n.seen_s = 1'b0;
            if (sp_irq)
               n.pif = 1'b1;
         end
         else if (r.sact && ls.scl_rise)
         begin
            if (r.scnt < BYTE_LAST)
            begin
               n.shift = {r.shift[6:0], ls.sda};
               n.scnt = r.scnt + 4'h1;
            end
            else
            begin
               n.scnt = ACK_END;
               // a not-acknowledge from the reading master ends the transfer
               if (r.rw && r.is_data && ls.sda)
                  n.sact = 1'b0;
            end
         end
         else if (r.sact && ls.scl_fall && r.scnt == BYTE_LAST)
         begin
            if (r.is_data)
               hit = !r.rw;
            else if (!ten_mode)
               hit = r.shift[7:1] == r.addr_reload[7:1]
                     || (r.ctrl2[C2_BCAST] && r.shift == BCAST_ADDR);
            else if (r.ten == TEN_HI)
               hit = r.shift[7:1] == r.addr_reload[7:1] && r.shift[7:3] == TEN_PREFIX && !r.shift[0];
            else if (r.ten == TEN_LO)
               hit = r.shift == r.addr_reload;
            else
               hit = r.shift[7:1] == r.addr_reload[7:1];
            ok = !r.buf_full && !r.ctrl1[C1_OVF];
            n.hit = hit;
            n.load = hit && ok;
            n.ack = hit && ok;
            if (hit && !ok && r.is_data)
               n.ctrl1[C1_OVF] = 1'b1;
            if (r.is_data && r.rw)
               n.buf_full = 1'b0;
            if (!r.is_data && !hit)
               n.sact = 1'b0;
         end
         else if (r.sact && ls.scl_fall && r.scnt == ACK_END)
         begin
            n.scnt = 4'h0;
            n.ack = 1'b0;
            if (r.is_data && r.rw)
            begin
               n.pif = 1'b1;
               if (!r.buf_full)
                  n.ctrl1[C1_REL] = 1'b0;
            end
            else if (r.hit)
            begin
               n.pif = 1'b1;
               if (r.load)
               begin
                  n.data_buf = r.shift;
                  n.buf_full = r.is_data || !r.shift[0];
               end
               if (!r.is_data && ten_mode && r.ten != TEN_DONE)
               begin
                  n.addr_upd = 1'b1;
                  n.ten = r.ten + 2'h1;
                  n.is_data = r.ten == TEN_LO;
                  n.rw = 1'b0;
               end
               else if (!r.is_data)
               begin
                  n.is_data = 1'b1;
                  n.rw = r.shift[0];
                  if (r.shift[0])
                     n.ctrl1[C1_REL] = 1'b0;
               end
               else if (r.ctrl2[C2_START] && r.load)
                  n.ctrl1[C1_REL] = 1'b0;
            end
         end
      end

      if (!en)
      begin
         n.seen_s = 1'b0;
         n.seen_p = 1'b0;
      end
      // open drain: only ever pull low, and only with the pin set as input
      n.scl_oe_n = !(i2c_sel && scl_dir_in_i && scl_low);
      n.sda_oe_n = !(i2c_sel && sda_dir_in_i && sda_low);
      n.port_on = en && i2c_sel;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         r <= '0;
         r.ctrl1 <= RST_REG;
         r.ctrl2 <= RST_REG;
         r.addr_reload <= RST_REG;
         r.ms <= M_IDLE;
         r.scl_oe_n <= 1'b1;
         r.sda_oe_n <= 1'b1;
      end
      else
         r <= n;
   end

   assign prdata_o = r.rdata;
   assign pready_o = r.ready;
   assign pslverr_o = r.err;
   assign scl_o = r.drv_lvl;
   assign sda_o = r.drv_lvl;
   assign scl_oe_n_o = r.scl_oe_n;
   assign sda_oe_n_o = r.sda_oe_n;
   assign pins_to_port_o = r.port_on;
   assign port_interrupt_flag_o = r.pif;
endmodule : i2c_port

// ===== design/i2c_port_pkg.sv
// constants and types shared by the two-wire serial port files
package i2c_port_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0C;
   localparam logic [7:0] OFS_ADDR = 8'h10;
   localparam logic [7:0] OFS_FLAG = 8'h14;
   localparam logic [7:0] RST_REG = 8'h00;
   // control one fields
   localparam int C1_COLL = 7;
   localparam int C1_OVF = 6;
   localparam int C1_EN = 5;
   localparam int C1_REL = 4;
   localparam int C1_MODE_HI = 3;
   // control two fields
   localparam int C2_BCAST = 7;
   localparam int C2_ACKST = 6;
   localparam int C2_ACKVAL = 5;
   localparam int C2_ACKGO = 4;
   localparam int C2_START = 0;
   localparam int C2_RXGO = 3;
   localparam int C2_STOP = 2;
   localparam int C2_RSTART = 1;
   // status fields
   localparam int ST_FULL = 0;
   localparam int ST_UPD = 1;
   localparam int ST_RW = 2;
   localparam int ST_SEEN_S = 3;
   localparam int ST_SEEN_P = 4;
   localparam int ST_DATA = 5;
   localparam int ST_MBUSY = 6;
   localparam int ST_RSVD = 7;
   // mode select codes
   localparam logic [3:0] MODE_SLV10_SP = 4'hF;
   localparam logic [3:0] MODE_SLV7_SP = 4'hE;
   localparam logic [3:0] MODE_FW_MST = 4'hB;
   localparam logic [3:0] MODE_MST = 4'h8;
   localparam logic [3:0] MODE_SLV10 = 4'h7;
   localparam logic [3:0] MODE_SLV7 = 4'h6;
   // bit counts and addressing
   localparam logic [4:0] TEN_PREFIX = 5'h1E;
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [3:0] BYTE_LAST = 4'h8;
   localparam logic [3:0] ACK_END = 4'h9;
   localparam logic [3:0] MST_RX_LAST = 4'h7;
   localparam logic [1:0] Q_SAMPLE = 2'h2;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] TEN_HI = 2'h0;
   localparam logic [1:0] TEN_LO = 2'h1;
   localparam logic [1:0] TEN_DONE = 2'h2;
   typedef enum logic [6:0] {
      M_IDLE = 7'h01, M_START = 7'h02, M_RSTART = 7'h04, M_STOP = 7'h08,
      M_TX = 7'h10, M_RX = 7'h20, M_ACK = 7'h40
   } mstate_t;
endpackage : i2c_port_pkg

// ===== design/line_sense.sv
// pin synchroniser with clock edge and start/stop detection
`timescale 1ns/1ps
module line_sense (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // raw bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   // conditioned view
   line_sense_if.src ls
);
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic rise;
      logic fall;
      logic start;
      logic stop;
   } sense_t;
   sense_t r, n;

   // s1 feeds only s2; all detection looks at s2 and s3
   always_comb
   begin
      n = r;
      n.s1 = {scl_i, sda_i};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.rise = r.s2[1] & ~r.s3[1];
      n.fall = ~r.s2[1] & r.s3[1];
      n.start = r.s2[1] & r.s3[1] & ~r.s2[0] & r.s3[0];
      n.stop = r.s2[1] & r.s3[1] & r.s2[0] & ~r.s3[0];
   end

   // idle bus reads high, so no false event after reset
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
         r <= {6'h3F, 4'h0};
      else
         r <= n;
   end

   assign ls.scl = r.s3[1];
   assign ls.sda = r.s3[0];
   assign ls.scl_rise = r.rise;
   assign ls.scl_fall = r.fall;
   assign ls.start = r.start;
   assign ls.stop = r.stop;
endmodule : line_sense

// ===== design/line_sense_if.sv
// synchronised bus levels and bus events
`timescale 1ns/1ps
interface line_sense_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport src (output scl, sda, scl_rise, scl_fall, start, stop);
   modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : line_sense_if

// ===== design/rate_gen.sv
// quarter-bit tick generator for the master clock
`timescale 1ns/1ps
module rate_gen (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic [6:0] reload_i,
   input wire logic run_i,
   // one-cycle tick every reload+1 clocks
   output logic tick_o
);
   typedef struct packed {
      logic [6:0] cnt;
      logic tick;
   } rate_t;
   rate_t r, n;

   always_comb
   begin
      n = r;
      n.tick = 1'b0;
      if (!run_i)
         n.cnt = 7'h00;
      else if (r.cnt == reload_i)
      begin
         n.cnt = 7'h00;
         n.tick = 1'b1;
      end
      else
         n.cnt = r.cnt + 7'h01;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
         r <= '0;
      else
         r <= n;
   end

   assign tick_o = r.tick;
endmodule : rate_gen
